// ==== rtl/sched_map.svh ====
// Register offsets, field positions, reset values and timing counts of the
// sample start/stop scheduler.
// Assumes a 100 MHz clock and a word register port with 8-bit addresses.
`ifndef SCHED_MAP_SVH
`define SCHED_MAP_SVH

// Timing
`define CLK_PERIOD_NS  10
`define SEC_NS         1000000000
`define SECS_PER_MIN   32'h0000003c
`define SR_MAX         5'h18

// Register offsets
`define A_CTRL         8'h00
`define A_CFG          8'h04
`define A_NOW          8'h08
`define A_PROG_START   8'h0c
`define A_DELAY        8'h10
`define A_INTERVAL     8'h14
`define A_COMP_CNT     8'h18
`define A_NU_CNT       8'h1c
`define A_SR_CNT       8'h20
`define A_SR_IDX       8'h24
`define A_SR_TIME      8'h28
`define A_STATUS       8'h2c
`define A_NU_TIME      8'h30

// Command bits
`define CTRL_START     0
`define CTRL_ABORT     1
`define CTRL_REINIT    2
`define CTRL_MANUAL    3

// Configuration bits
`define CFG_FLOW       0
`define CFG_NONUNIF    1
`define CFG_SR_EN      2
`define CFG_ON_STOP    3
`define CFG_ON_RESUME  4
`define CFG_FLOW_START 5
`define CFG_ON_ENABLE  6
`define CFG_PROG_START 7

// Reset values
`define CFG_RESET      8'h00
`define DELAY_RESET    32'h00000002
`define INTERVAL_RESET 32'h00000e10
`define COUNT_RESET    32'h0000000a

`endif

// ==== rtl/sched_pkg.sv ====
// Types shared by the scheduler files.
// Assumes nothing of its surroundings.
`default_nettype none

package sched_pkg;

    // Phases of a sampling routine
    typedef enum logic [2:0] {PH_IDLE, PH_DELAY, PH_SUSP, PH_RUN, PH_PAUSED, PH_DONE} phase_t;

endpackage

`default_nettype wire

// ==== rtl/pin_sync.sv ====
// Two-flop synchronisers with rising-edge detect for external pins.
// Assumes the pins are asynchronous to clk.
`default_nettype none

module pin_sync #(
    parameter int N = 3
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Raw pins and synchronised views
    input  wire logic [N-1:0] pin_in,
    output logic [N-1:0]      level,
    output logic [N-1:0]      rise
);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
    } sync_t;

    sync_t r_reg;
    sync_t r_next;

    // Shift chain; only s2 and s3 are looked at
    always_comb
    begin
        r_next.s1 = pin_in;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
    end

    // State register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-bit level and edge
    for (genvar i = 0; i < N; i++)
    begin : g_bit
        assign level[i] = r_reg.s2[i];
        assign rise[i]  = r_reg.s2[i] & ~r_reg.s3[i];
    end

endmodule

`default_nettype wire

// ==== rtl/sample_start_stop_scheduler.sv ====
// Sample start/stop scheduler: start time, pacing, stop/resume, enable gate.
// Assumes flow meter pins are asynchronous and the register master is on clk.
//
// The address map and the address-and-strobe port were left to the implementer.
`include "sched_map.svh"
`default_nettype none

module sample_start_stop_scheduler #(
    parameter int TICK_CYCLES = `SEC_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [31:0]      rdata,
    // Flow meter and float pins
    input  wire logic        enable_pin,
    input  wire logic        flow_pulse_pin,
    input  wire logic        float_off_pin,
    // Sequencer request and status
    output logic             sample_req,
    output logic             running,
    output logic             done,
    output sched_pkg::phase_t phase
);
    import sched_pkg::*;

    typedef struct packed {
        phase_t           phase;
        logic [31:0]      now;
        logic [31:0]      tick_cnt;
        logic [7:0]       cfg;
        logic [31:0]      prog_start;
        logic [31:0]      delay_min;
        logic [31:0]      interval;
        logic [31:0]      comp_cnt;
        logic [31:0]      nu_cnt;
        logic [4:0]       sr_cnt;
        logic [4:0]       sr_idx;
        logic [23:0][31:0] sr_time;
        logic [31:0]      nu_time;
        logic             nu_done;
        logic             nu_missed;
        logic [4:0]       sr_ptr;
        logic [31:0]      delay_left;
        logic [31:0]      ivl_cnt;
        logic [31:0]      samples;
        logic [31:0]      rdata;
        logic             sample_req;
        logic             running;
        logic             done;
    } state_t;

    localparam state_t ST_RESET = '{phase: PH_IDLE, cfg: `CFG_RESET, delay_min: `DELAY_RESET,
                                    interval: `INTERVAL_RESET, comp_cnt: `COUNT_RESET,
                                    nu_cnt: `COUNT_RESET, default: '0};

    state_t      r_reg;
    state_t      r_next;
    logic [2:0]  pin_level;
    logic [2:0]  pin_rise;
    logic        enabled;
    logic        flow_rise;
    logic        float_off;
    logic        sec_tick;
    logic        start_cmd;
    logic        abort_cmd;
    logic        reinit_cmd;
    logic        manual_cmd;
    logic        flow_mode;
    logic        nonunif;
    logic        sample_on_stop_cfg;
    logic        sample_on_resume_cfg;
    logic        flow_sample_on_start_cfg;
    logic        sample_on_enable_cfg;
    logic        sr_on;
    logic        sr_hit;
    logic        nu_due;
    logic        start_now;
    logic        fire;
    logic [31:0] limit;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    pin_sync #(
        .N (3)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pin_in  ({float_off_pin, flow_pulse_pin, enable_pin}),
        .level   (pin_level),
        .rise    (pin_rise)
    );

    // Flow meter gate level and pacing pulses
    assign enabled   = pin_level[0];
    assign flow_rise = pin_rise[1];
    assign float_off = pin_level[2];

    ////////////////////////////////////////////////////////////////////////////
    // Commands and configuration views
    assign sec_tick   = (r_reg.tick_cnt == 32'(TICK_CYCLES - 1));
    assign start_cmd  = wr_en && (addr == `A_CTRL) && wdata[`CTRL_START];
    assign abort_cmd  = wr_en && (addr == `A_CTRL) && wdata[`CTRL_ABORT];
    assign reinit_cmd = wr_en && (addr == `A_CTRL) && wdata[`CTRL_REINIT];
    assign manual_cmd = wr_en && (addr == `A_CTRL) && wdata[`CTRL_MANUAL];

    assign flow_mode                = r_reg.cfg[`CFG_FLOW];
    assign nonunif                  = r_reg.cfg[`CFG_NONUNIF];
    assign sample_on_stop_cfg       = r_reg.cfg[`CFG_ON_STOP];
    assign sample_on_resume_cfg     = r_reg.cfg[`CFG_ON_RESUME];
    assign flow_sample_on_start_cfg = r_reg.cfg[`CFG_FLOW_START];
    assign sample_on_enable_cfg     = r_reg.cfg[`CFG_ON_ENABLE];

    // Stop/resume schedule active only with a nonzero count
    assign sr_on  = r_reg.cfg[`CFG_SR_EN] && (r_reg.sr_cnt != 5'h00);
    assign sr_hit = sr_on && (r_reg.sr_ptr < r_reg.sr_cnt) && (r_reg.now >= r_reg.sr_time[r_reg.sr_ptr]);
    assign nu_due = nonunif && !r_reg.nu_done && (r_reg.now >= r_reg.nu_time);

    // Sample limit source
    assign limit = nonunif ? r_reg.nu_cnt : r_reg.comp_cnt;

    // Programmed time wins over the delay countdown
    assign start_now = r_reg.cfg[`CFG_PROG_START] ? (r_reg.now >= r_reg.prog_start)
                                                  : (r_reg.delay_left == 32'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        r_next = r_reg;
        fire   = 1'b0;

        // Seconds time base
        if (sec_tick)
        begin
            r_next.tick_cnt = 32'h0;
            r_next.now      = r_reg.now + 32'h1;
        end
        else
            r_next.tick_cnt = r_reg.tick_cnt + 32'h1;

        // Register writes
        if (wr_en)
        begin
            if (addr == `A_CFG)
                r_next.cfg = wdata[7:0];
            else if (addr == `A_NOW)
                r_next.now = wdata;
            else if (addr == `A_PROG_START)
                r_next.prog_start = wdata;
            else if (addr == `A_DELAY)
                r_next.delay_min = wdata;
            else if (addr == `A_INTERVAL)
                r_next.interval = wdata;
            else if (addr == `A_COMP_CNT)
                r_next.comp_cnt = wdata;
            else if (addr == `A_NU_CNT)
                r_next.nu_cnt = wdata;
            else if (addr == `A_SR_CNT)
            begin
                if (r_reg.cfg[`CFG_SR_EN] && (wdata <= 32'(`SR_MAX)))
                    r_next.sr_cnt = wdata[4:0];
            end
            else if (addr == `A_SR_IDX)
                r_next.sr_idx = wdata[4:0];
            else if (addr == `A_SR_TIME)
            begin
                if (r_reg.sr_idx < `SR_MAX)
                    r_next.sr_time[r_reg.sr_idx] = wdata;
            end
            else if (addr == `A_NU_TIME)
            begin
                r_next.nu_time = wdata;
                r_next.nu_done = 1'b0;
            end
        end

        // Register reads, data valid the next cycle
        r_next.rdata = 32'h0;
        if (rd_en)
        begin
            if (addr == `A_CFG)
                r_next.rdata = {24'h000000, r_reg.cfg};
            else if (addr == `A_NOW)
                r_next.rdata = r_reg.now;
            else if (addr == `A_PROG_START)
                r_next.rdata = r_reg.prog_start;
            else if (addr == `A_DELAY)
                r_next.rdata = r_reg.delay_min;
            else if (addr == `A_INTERVAL)
                r_next.rdata = r_reg.interval;
            else if (addr == `A_COMP_CNT)
                r_next.rdata = r_reg.comp_cnt;
            else if (addr == `A_NU_CNT)
                r_next.rdata = r_reg.nu_cnt;
            else if (addr == `A_SR_CNT)
                r_next.rdata = {27'h0000000, r_reg.sr_cnt};
            else if (addr == `A_SR_IDX)
                r_next.rdata = {27'h0000000, r_reg.sr_idx};
            else if (addr == `A_SR_TIME)
                r_next.rdata = (r_reg.sr_idx < `SR_MAX) ? r_reg.sr_time[r_reg.sr_idx] : 32'h0;
            else if (addr == `A_STATUS)
                r_next.rdata = {5'h00, r_reg.sr_ptr, r_reg.nu_done, r_reg.done, r_reg.running,
                                3'(r_reg.phase), r_reg.samples[15:0]};
            else if (addr == `A_NU_TIME)
                r_next.rdata = r_reg.nu_time;
        end

        // Re-initialize restores defaults, clock kept
        if (reinit_cmd)
        begin
            r_next          = ST_RESET;
            r_next.now      = r_reg.now;
            r_next.tick_cnt = r_reg.tick_cnt;
        end
        else if (abort_cmd)
            r_next.phase = PH_IDLE;
        else
        begin
            case (r_reg.phase)
                PH_IDLE, PH_DONE:
                begin
                    // Nothing runs before the start command
                    if (start_cmd)
                    begin
                        r_next.phase      = PH_DELAY;
                        r_next.delay_left = 32'(r_reg.delay_min * `SECS_PER_MIN);
                        r_next.sr_ptr     = 5'h00;
                        r_next.samples    = 32'h0;
                        r_next.nu_missed  = 1'b0;
                    end
                end
                PH_DELAY:
                begin
                    // Manual requests not looked at here; enable pin only read once the start time is reached
                    if (sec_tick && (r_reg.delay_left != 32'h0))
                        r_next.delay_left = r_reg.delay_left - 32'h1;
                    if (start_now)
                    begin
                        r_next.ivl_cnt = 32'h0;
                        if (enabled)
                        begin
                            r_next.phase = PH_RUN;
                            fire = !flow_mode || flow_sample_on_start_cfg;
                        end
                        else
                            r_next.phase = PH_SUSP;
                    end
                end
                PH_SUSP:
                begin
                    // Missed nonuniform events collapse to one
                    if (nu_due)
                        r_next.nu_missed = 1'b1;
                    if (float_off)
                        r_next.phase = PH_DONE;
                    else if (enabled)
                    begin
                        r_next.phase   = PH_RUN;
                        r_next.ivl_cnt = 32'h0;
                        fire = !flow_mode || sample_on_enable_cfg;
                        if (r_reg.nu_missed || nu_due)
                        begin
                            fire             = 1'b1;
                            r_next.nu_done   = 1'b1;
                            r_next.nu_missed = 1'b0;
                        end
                    end
                end
                PH_RUN:
                begin
                    if (float_off)
                        r_next.phase = PH_DONE;
                    else if (!enabled)
                        r_next.phase = PH_SUSP;
                    else if (sr_hit)
                    begin
                        r_next.sr_ptr = r_reg.sr_ptr + 5'h01;
                        if (!r_reg.sr_ptr[0])
                        begin
                            // Stop suppresses any coinciding interval sample
                            fire = sample_on_stop_cfg;
                            if (r_reg.sr_ptr + 5'h02 >= r_reg.sr_cnt)
                                r_next.phase = PH_DONE;
                            else
                                r_next.phase = PH_PAUSED;
                        end
                    end
                    else
                    begin
                        // Pacing
                        if (flow_mode)
                        begin
                            if (flow_rise)
                            begin
                                r_next.ivl_cnt = r_reg.ivl_cnt + 32'h1;
                                if (r_reg.ivl_cnt + 32'h1 >= r_reg.interval)
                                begin
                                    fire           = 1'b1;
                                    r_next.ivl_cnt = 32'h0;
                                end
                            end
                        end
                        else if (nonunif)
                        begin
                            if (nu_due)
                            begin
                                fire           = 1'b1;
                                r_next.nu_done = 1'b1;
                            end
                        end
                        else if (sec_tick)
                        begin
                            r_next.ivl_cnt = r_reg.ivl_cnt + 32'h1;
                            if (r_reg.ivl_cnt + 32'h1 >= r_reg.interval)
                            begin
                                fire           = 1'b1;
                                r_next.ivl_cnt = 32'h0;
                            end
                        end
                        // Manual request only while running
                        if (manual_cmd)
                            fire = 1'b1;
                    end
                end
                PH_PAUSED:
                begin
                    if (float_off)
                        r_next.phase = PH_DONE;
                    else if (sr_hit)
                    begin
                        r_next.sr_ptr  = r_reg.sr_ptr + 5'h01;
                        r_next.phase   = PH_RUN;
                        r_next.ivl_cnt = 32'h0;
                        fire = sample_on_resume_cfg;
                    end
                end
                default:
                    r_next.phase = PH_IDLE;
            endcase

            // Count samples; zero limit means no limit
            if (fire)
            begin
                r_next.samples = r_reg.samples + 32'h1;
                if ((limit != 32'h0) && (r_reg.samples + 32'h1 >= limit))
                    r_next.phase = PH_DONE;
            end
        end

        // One merged request per decision
        r_next.sample_req = fire;
        r_next.running    = (r_next.phase == PH_RUN) || (r_next.phase == PH_PAUSED) ||
                            (r_next.phase == PH_SUSP);
        r_next.done       = (r_next.phase == PH_DONE);
    end

    // State register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            r_reg <= ST_RESET;
        else
            r_reg <= r_next;
    end

    // Outputs straight from flops
    assign rdata      = r_reg.rdata;
    assign sample_req = r_reg.sample_req;
    assign running    = r_reg.running;
    assign done       = r_reg.done;
    assign phase      = r_reg.phase;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_sr_count_range: assert property (r_reg.sr_cnt <= `SR_MAX)
        else $error("stop/resume count above 24");
    a_sr_count_gate: assert property (wr_en && addr == `A_SR_CNT && !r_reg.cfg[`CFG_SR_EN]
        |=> $stable(r_reg.sr_cnt)) else $error("count taken while feature off");
    a_stop_no_sample: assert property (r_reg.phase == PH_RUN && enabled && !float_off && sr_hit
        && !r_reg.sr_ptr[0] && !sample_on_stop_cfg && !wr_en |=> !sample_req)
        else $error("sample fired at stop");
    a_resume_sample: assert property (r_reg.phase == PH_PAUSED && sr_hit && !float_off && !wr_en
        |=> sample_req == $past(sample_on_resume_cfg)) else $error("resume sampling wrong");
    a_delay_hold: assert property (r_reg.phase == PH_DELAY && !start_now && !wr_en
        |=> r_reg.phase == PH_DELAY) else $error("left delay early");
    a_start_time_fire: assert property (r_reg.phase == PH_DELAY && start_now && enabled
        && !flow_mode && !wr_en |=> sample_req && r_reg.phase != PH_SUSP)
        else $error("no sample at time-paced start");
    a_flow_start: assert property (r_reg.phase == PH_DELAY && start_now && enabled && flow_mode
        && !flow_sample_on_start_cfg |=> !sample_req) else $error("flow start sampled");
    a_susp_at_start: assert property (r_reg.phase == PH_DELAY && start_now && !enabled && !wr_en
        |=> r_reg.phase == PH_SUSP && !sample_req) else $error("not suspended at start");
    a_enable_fire: assert property (r_reg.phase == PH_SUSP && enabled && !float_off && !flow_mode
        && !wr_en |=> sample_req && r_reg.phase == PH_RUN) else $error("no sample on enable");
    a_susp_quiet: assert property (r_reg.phase == PH_SUSP && !enabled |=> !sample_req)
        else $error("sample while disabled");
    a_reinit_cfg: assert property (reinit_cmd |=> !sample_on_stop_cfg && !sample_on_resume_cfg
        && r_reg.phase == PH_IDLE) else $error("re-initialize kept settings");

    c_start_run: cover property (r_reg.phase == PH_DELAY ##1 r_reg.phase == PH_RUN);
    c_susp_resume: cover property (r_reg.phase == PH_SUSP ##1 r_reg.phase == PH_RUN);
    c_pause_resume: cover property (r_reg.phase == PH_PAUSED ##1 r_reg.phase == PH_RUN);
    c_done: cover property (r_reg.phase == PH_RUN ##1 r_reg.phase == PH_DONE);

endmodule

`default_nettype wire

// ==== verif/flow_meter_model.sv ====
// Flow meter model: enable level and flow pulses for the scheduler.
// Assumes the bench raises its requests just after a rising clk edge.
`default_nettype none

module flow_meter_model (
    // Clock and bench requests
    input  wire logic clk,
    input  wire logic want_en,
    input  wire logic pulse_go,
    // Meter pins
    output var logic  enable_pin,
    output var logic  flow_pulse_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;

    ////////////////////////////////////////////////////////////////
    // Enable follows request; each pulse is a few cycles high
    always @(posedge clk)
    begin
        enable_pin <= want_en;
        if (pulse_go)
            cnt <= 6;
        else if (cnt > 0)
            cnt <= cnt - 1;
        flow_pulse_pin <= (cnt > 3);
    end
endmodule

`default_nettype wire

// ==== verif/sample_start_stop_scheduler_bench.sv ====
// Self-checking bench for the scheduler with a flow meter model.
// Assumes TICK_CYCLES of 10 so that one second lasts ten clocks.
`include "sched_map.svh"
`default_nettype none

module sample_start_stop_scheduler_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import sched_pkg::*;
    logic        clk, reset_n, wr_en, rd_en, want_en, pulse_go, float_off;
    logic        enable_pin, flow_pulse_pin, sample_req, running, done, rd_d;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, seed;
    logic [31:0] exp_q[$];
    phase_t      phase;
    int          mismatches, check_count, reqs, base;

    sample_start_stop_scheduler #(.TICK_CYCLES(10)) dut (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .enable_pin(enable_pin),
        .flow_pulse_pin(flow_pulse_pin), .float_off_pin(float_off), .sample_req(sample_req),
        .running(running), .done(done), .phase(phase));
    flow_meter_model meter (.clk(clk), .want_en(want_en), .pulse_go(pulse_go),
        .enable_pin(enable_pin), .flow_pulse_pin(flow_pulse_pin));

    ////////////////////////////////////////////////////////////////
    // Clock, watchdog and helpers
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200000;
        mismatches++;
        end_sim;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
        check_count++;
        if (seen !== expd)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
    endtask
    // Settle, then compare request count and phase
    task automatic st(input logic [31:0] n, input phase_t p);
        repeat (12) @(posedge clk);
        chk(reqs - base, n);
        chk(phase, p);
        chk(running, 32'((p == PH_SUSP) || (p == PH_RUN) || (p == PH_PAUSED)));
        chk(done, 32'(p == PH_DONE));
        base = reqs;
    endtask
    // Restart the clock at zero, then start
    task automatic go;
        wr(`A_NOW, 32'h0);
        wr(`A_CTRL, 32'h1);
    endtask
    task automatic pulse;
        pulse_go <= 1'b1;
        @(posedge clk);
        pulse_go <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////
    // Output monitor: read data and sample requests
    always @(posedge clk)
    begin
        rd_d <= rd_en;
        if (sample_req === 1'b1)
            reqs <= reqs + 1;
    end
    always @(negedge clk)
        if (rd_d === 1'b1)
            chk(rdata, exp_q.pop_front());

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {reset_n, addr, wdata, wr_en, rd_en, pulse_go, float_off} = '0;
        {want_en, seed, base} = {1'b1, 32'h0544503e, 32'h0};
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(`A_CFG, 32'h0);
        rd(`A_DELAY, `DELAY_RESET);
        rd(`A_INTERVAL, `INTERVAL_RESET);
        rd(8'h40, 32'h0);
        seed = xs(seed);
        wr(8'h44, seed);
        rd(`A_CFG, 32'h0);
        $display("test reset done");
        wr(`A_DELAY, 32'h0);
        wr(`A_CTRL, 32'h1);
        st(1, PH_RUN);
        want_en <= 1'b0;
        st(0, PH_SUSP);
        wr(`A_CTRL, 32'h8);
        st(0, PH_SUSP);
        want_en <= 1'b1;
        st(1, PH_RUN);
        float_off <= 1'b1;
        st(0, PH_DONE);
        float_off <= 1'b0;
        $display("test time pacing done");
        wr(`A_CFG, 32'h1);
        wr(`A_INTERVAL, 32'h2);
        wr(`A_CTRL, 32'h1);
        st(0, PH_RUN);
        pulse;
        pulse;
        st(1, PH_RUN);
        want_en <= 1'b0;
        st(0, PH_SUSP);
        want_en <= 1'b1;
        st(0, PH_RUN);
        wr(`A_CTRL, 32'h2);
        wr(`A_CFG, 32'h21);
        wr(`A_CTRL, 32'h1);
        st(1, PH_RUN);
        wr(`A_CFG, 32'h61);
        want_en <= 1'b0;
        st(0, PH_SUSP);
        want_en <= 1'b1;
        st(1, PH_RUN);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        st(0, PH_IDLE);
        rd(`A_INTERVAL, `INTERVAL_RESET);
        $display("test flow pacing done");
        wr(`A_CTRL, 32'h2);
        wr(`A_CFG, 32'h0);
        wr(`A_DELAY, 32'h1);
        want_en <= 1'b0;
        wr(`A_CTRL, 32'h1);
        st(0, PH_DELAY);
        repeat (600) @(posedge clk);
        st(0, PH_SUSP);
        want_en <= 1'b1;
        st(1, PH_RUN);
        wr(`A_CTRL, 32'h2);
        $display("test delayed start done");
        wr(`A_SR_CNT, 32'h5);
        rd(`A_SR_CNT, 32'h0);
        wr(`A_CFG, 32'h1c);
        wr(`A_SR_CNT, 32'h19);
        rd(`A_SR_CNT, 32'h0);
        wr(`A_SR_CNT, 32'h18);
        rd(`A_SR_CNT, 32'h18);
        wr(`A_CTRL, 32'h4);
        rd(`A_CFG, 32'h0);
        $display("test settings done");
        wr(`A_CFG, 32'h1c);
        wr(`A_SR_CNT, 32'h3);
        for (int i = 0; i < 3; i++)
        begin
            wr(`A_SR_IDX, i);
            wr(`A_SR_TIME, 2 * i + 4);
        end
        wr(`A_DELAY, 32'h0);
        go;
        repeat (100) @(posedge clk);
        st(4, PH_DONE);
        wr(`A_CFG, 32'h04);
        wr(`A_COMP_CNT, 32'h0);
        go;
        repeat (100) @(posedge clk);
        st(1, PH_DONE);
        wr(`A_SR_CNT, 32'h0);
        go;
        repeat (100) @(posedge clk);
        st(1, PH_RUN);
        $display("test schedule done");
        wr(`A_CTRL, 32'h2);
        wr(`A_DELAY, 32'h1);
        wr(`A_PROG_START, 32'h3);
        wr(`A_CFG, 32'h80);
        go;
        st(0, PH_DELAY);
        repeat (30) @(posedge clk);
        st(1, PH_RUN);
        $display("test start time done");
        wr(`A_CTRL, 32'h2);
        wr(`A_DELAY, 32'h0);
        wr(`A_CFG, 32'h02);
        wr(`A_NU_CNT, 32'h3);
        wr(`A_NU_TIME, 32'h6);
        go;
        st(1, PH_RUN);
        want_en <= 1'b0;
        repeat (60) @(posedge clk);
        st(0, PH_SUSP);
        want_en <= 1'b1;
        st(1, PH_RUN);
        wr(`A_NU_TIME, 32'h0);
        st(1, PH_DONE);
        $display("test nonuniform done");
        end_sim;
    end
endmodule

`default_nettype wire
